/* File: pmd_clock_gen.sv */
// Clock multiplier and divider configuration registers with the divider chain
// Functional notes
// - Multiplier field selects x4 to x25 only
// - Unused upper register bits read zero
// - Divider enable bit 15, zero stops clock
// - Five-bit ratio field, 0 means divide-by-one
// - Reset ratios: /1, /1, /2, /2
// - Oscillator divider enable bit 15, resets one
// - Oscillator ratio bits 4:0, resets /8
// - Oscillator output bypasses PLL and prescaler
// - Registers decoded at their fixed addresses
// - Mode bit selects reference or PLL source
// - Memory clock from third divider or pin
`timescale 1ns/1ps
`include "pmd_defs.svh"
module pmd_clock_gen (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic osc_clock_in,
    input wire logic pll_output_clock,
    input wire logic memif_ext_clock_in,
    input wire logic memif_clock_source_sel,
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    output logic pll_ref_clock,
    output pmd_pkg::pmd_ratio_t pll_multiply_ratio,
    output logic pll_mode_select,
    output logic core_system_clock,
    output logic periph_bus_clock,
    output logic memif_system_clock,
    output logic osc_clock_output
);
    import pmd_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [2:0] reg_index(input logic [31:0] addr);
        logic [2:0] idx;
        idx = `PMD_IDX_NONE;
        case (addr)
            `PMD_ADDR_DIV0: idx = `PMD_IDX_DIV0;
            `PMD_ADDR_DIV1: idx = `PMD_IDX_DIV1;
            `PMD_ADDR_DIV2: idx = `PMD_IDX_DIV2;
            `PMD_ADDR_DIV3: idx = `PMD_IDX_DIV3;
            `PMD_ADDR_OSC: idx = `PMD_IDX_OSC;
            `PMD_ADDR_MULT: idx = `PMD_IDX_MULT;
            `PMD_ADDR_CSR: idx = `PMD_IDX_CSR;
            default: idx = `PMD_IDX_NONE;
        endcase
        return idx;
    endfunction : reg_index

    function automatic logic [31:0] pack_div(input logic en, input pmd_ratio_t ratio);
        logic [31:0] word;
        word = 32'h0000_0000;
        word[`PMD_EN_BIT] = en;
        word[`PMD_RATIO_MSB:0] = ratio;
        return word;
    endfunction : pack_div

    // A change is accepted once the second and third stages agree on a new level
    function automatic logic sync_change(input logic [2:0] s, input logic lvl);
        return (s[1] == s[2]) && (s[2] != lvl);
    endfunction : sync_change

    // ----------------------------------------
    // State
    // ----------------------------------------
    pmd_top_state_t st_ff;
    pmd_top_state_t nxt_st;
    logic osc_tick;
    logic pll_tick;
    logic sys_tick;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic [4:0] div_clk;

    pmd_div_if div_bus[`PMD_NUM_DIV] ();

    assign osc_tick = sync_change(st_ff.osc_sync, st_ff.osc_lvl);
    assign pll_tick = sync_change(st_ff.pll_sync, st_ff.pll_lvl);
    // Bypass feeds the post-scalers straight from the reference
    assign sys_tick = st_ff.pll_mode ? pll_tick : osc_tick;
    assign wr_idx = reg_index(reg_addr);
    assign rd_idx = reg_index(reg_addr);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.osc_sync = {st_ff.osc_sync[1:0], osc_clock_in};
        nxt_st.pll_sync = {st_ff.pll_sync[1:0], pll_output_clock};
        nxt_st.ext_sync = {st_ff.ext_sync[1:0], memif_ext_clock_in};
        if (st_ff.osc_sync[1] == st_ff.osc_sync[2])
        begin
            nxt_st.osc_lvl = st_ff.osc_sync[2];
        end
        if (st_ff.pll_sync[1] == st_ff.pll_sync[2])
        begin
            nxt_st.pll_lvl = st_ff.pll_sync[2];
        end
        if (st_ff.ext_sync[1] == st_ff.ext_sync[2])
        begin
            nxt_st.ext_lvl = st_ff.ext_sync[2];
        end
        // Selecting the pin source when it is chosen; the third divider keeps running
        nxt_st.memif_clk = memif_clock_source_sel ? st_ff.ext_lvl : div_clk[`PMD_IDX_DIV3];

        if (reg_wr)
        begin
            case (wr_idx)
                `PMD_IDX_DIV0, `PMD_IDX_DIV1, `PMD_IDX_DIV2, `PMD_IDX_DIV3, `PMD_IDX_OSC:
                begin
                    nxt_st.div_en[wr_idx] = reg_wdata[`PMD_EN_BIT];
                    nxt_st.div_ratio[wr_idx] = reg_wdata[`PMD_RATIO_MSB:0];
                end
                `PMD_IDX_MULT:
                begin
                    // Reserved codes are dropped so the PLL never sees an unsupported ratio
                    if (reg_wdata[`PMD_RATIO_MSB:0] >= `PMD_MULT_MIN && reg_wdata[`PMD_RATIO_MSB:0] <= `PMD_MULT_MAX)
                    begin
                        nxt_st.mult = reg_wdata[`PMD_RATIO_MSB:0];
                    end
                end
                `PMD_IDX_CSR:
                begin
                    nxt_st.pll_mode = reg_wdata[`PMD_MODE_BIT];
                end
                default:
                begin
                    nxt_st.pll_mode = st_ff.pll_mode;
                end
            endcase
        end

        nxt_st.rvalid = reg_rd;
        nxt_st.rdata = 32'h0000_0000;
        if (reg_rd)
        begin
            case (rd_idx)
                `PMD_IDX_DIV0, `PMD_IDX_DIV1, `PMD_IDX_DIV2, `PMD_IDX_DIV3, `PMD_IDX_OSC:
                begin
                    nxt_st.rdata = pack_div(st_ff.div_en[rd_idx], st_ff.div_ratio[rd_idx]);
                end
                `PMD_IDX_MULT:
                begin
                    nxt_st.rdata[`PMD_RATIO_MSB:0] = st_ff.mult;
                end
                `PMD_IDX_CSR:
                begin
                    nxt_st.rdata[`PMD_MODE_BIT] = st_ff.pll_mode;
                end
                default:
                begin
                    nxt_st.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= '0;
            st_ff.mult <= `PMD_MULT_RST;
            st_ff.pll_mode <= `PMD_MODE_RST;
            st_ff.div_en <= {`PMD_NUM_DIV{`PMD_EN_RST}};
            st_ff.div_ratio[`PMD_IDX_DIV0] <= `PMD_RATIO_DIV1;
            st_ff.div_ratio[`PMD_IDX_DIV1] <= `PMD_RATIO_DIV1;
            st_ff.div_ratio[`PMD_IDX_DIV2] <= `PMD_RATIO_DIV2;
            st_ff.div_ratio[`PMD_IDX_DIV3] <= `PMD_RATIO_DIV2;
            st_ff.div_ratio[`PMD_IDX_OSC] <= `PMD_RATIO_OSC_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Divider chain
    // ----------------------------------------
    // Prescaler and oscillator divider always count the raw reference
    genvar gi;
    generate
        for (gi = 0; gi < `PMD_NUM_DIV; gi++)
        begin : g_div
            if (gi == `PMD_IDX_DIV0 || gi == `PMD_IDX_OSC)
            begin : g_ref
                assign div_bus[gi].tick = osc_tick;
            end
            else
            begin : g_sys
                assign div_bus[gi].tick = sys_tick;
            end
            assign div_bus[gi].en = st_ff.div_en[gi];
            assign div_bus[gi].ratio = st_ff.div_ratio[gi];
            assign div_clk[gi] = div_bus[gi].clk_out;
            pmd_divider pmd_divider_i (
                .clock(clock),
                .rst_b(rst_b),
                .bus(div_bus[gi])
            );
        end
    endgenerate

    // Software alone keeps the peripheral ratio at twice the core ratio and orders the writes
    assign pll_ref_clock = div_clk[`PMD_IDX_DIV0];
    assign core_system_clock = div_clk[`PMD_IDX_DIV1];
    assign periph_bus_clock = div_clk[`PMD_IDX_DIV2];
    assign memif_system_clock = st_ff.memif_clk;
    assign osc_clock_output = div_clk[`PMD_IDX_OSC];
    assign pll_multiply_ratio = st_ff.mult;
    assign pll_mode_select = st_ff.pll_mode;
    assign reg_rdata = st_ff.rdata;
    assign reg_rvalid = st_ff.rvalid;

endmodule : pmd_clock_gen

/* File: pmd_defs.svh */
// Register map, field positions and reset values for the clock multiplier and divider block
`ifndef PMD_DEFS_SVH
`define PMD_DEFS_SVH

`define PMD_ADDR_CSR 32'h01b7c100
`define PMD_ADDR_MULT 32'h01b7c110
`define PMD_ADDR_DIV0 32'h01b7c114
`define PMD_ADDR_DIV1 32'h01b7c118
`define PMD_ADDR_DIV2 32'h01b7c11c
`define PMD_ADDR_DIV3 32'h01b7c120
`define PMD_ADDR_OSC 32'h01b7c124

`define PMD_IDX_DIV0 3'h0
`define PMD_IDX_DIV1 3'h1
`define PMD_IDX_DIV2 3'h2
`define PMD_IDX_DIV3 3'h3
`define PMD_IDX_OSC 3'h4
`define PMD_IDX_MULT 3'h5
`define PMD_IDX_CSR 3'h6
`define PMD_IDX_NONE 3'h7

`define PMD_EN_BIT 15
`define PMD_RATIO_MSB 4
`define PMD_MODE_BIT 0

`define PMD_MULT_MIN 5'h04
`define PMD_MULT_MAX 5'h19
`define PMD_MULT_RST 5'h04
`define PMD_RATIO_DIV1 5'h00
`define PMD_RATIO_DIV2 5'h01
`define PMD_RATIO_OSC_RST 5'h07
`define PMD_EN_RST 1'b1
`define PMD_MODE_RST 1'b0

`define PMD_NUM_DIV 5
`define PMD_SYNC_LEN 3

`endif

/* File: pmd_pkg.sv */
// Types shared by the clock multiplier and divider block
package pmd_pkg;

    typedef logic [4:0] pmd_ratio_t;

    typedef struct packed
    {
        pmd_ratio_t cnt;
        logic clk_out;
    } pmd_div_state_t;

    typedef struct packed
    {
        logic [2:0] osc_sync;
        logic [2:0] pll_sync;
        logic [2:0] ext_sync;
        logic osc_lvl;
        logic pll_lvl;
        logic ext_lvl;
        pmd_ratio_t mult;
        logic pll_mode;
        logic [4:0] div_en;
        logic [4:0][4:0] div_ratio;
        logic memif_clk;
        logic [31:0] rdata;
        logic rvalid;
    } pmd_top_state_t;

endpackage : pmd_pkg

/* File: pmd_div_if.sv */
// Control and output signals between the register block and one clock divider
`timescale 1ns/1ps
interface pmd_div_if;
    import pmd_pkg::*;
    logic tick;
    logic en;
    pmd_ratio_t ratio;
    logic clk_out;
    modport ctl (output tick, output en, output ratio, input clk_out);
    modport div (input tick, input en, input ratio, output clk_out);
endinterface : pmd_div_if

/* File: pmd_divider.sv */
// One clock divider: counts input transitions and toggles its output clock
`timescale 1ns/1ps
module pmd_divider (
    input wire logic clock,
    input wire logic rst_b,
    pmd_div_if.div bus
);
    import pmd_pkg::*;

    pmd_div_state_t st_ff;
    pmd_div_state_t nxt_st;

    // Toggling after ratio+1 transitions gives a period of ratio+1 input periods with an even duty cycle
    always_comb
    begin
        nxt_st = st_ff;
        if (!bus.en)
        begin
            nxt_st.cnt = `PMD_RATIO_DIV1;
            nxt_st.clk_out = 1'b0;
        end
        else if (bus.tick)
        begin
            // >= lets a shortened ratio take effect without a full counter wrap
            if (st_ff.cnt >= bus.ratio)
            begin
                nxt_st.cnt = `PMD_RATIO_DIV1;
                nxt_st.clk_out = ~st_ff.clk_out;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign bus.clk_out = st_ff.clk_out;

endmodule : pmd_divider

/* File: pmd_clock_gen_chk.sv */
// Register bus assertions for the clock generator
`timescale 1ns/1ps
`include "pmd_defs.svh"
module pmd_clock_gen_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire pmd_pkg::pmd_ratio_t pll_multiply_ratio,
    input wire logic pll_mode_select
);
    import pmd_pkg::*;
    logic mw;
    logic mok;
    logic cw;
    logic [4:0] wcode;
    assign wcode = reg_wdata[4:0];
    assign mw = reg_wr && reg_addr == `PMD_ADDR_MULT;
    assign mok = wcode >= `PMD_MULT_MIN && wcode <= `PMD_MULT_MAX;
    assign cw = reg_wr && reg_addr == `PMD_ADDR_CSR;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // ----
    // Bus answers and register write effects
    // ----
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe got no answer");
    a_answer_once: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read strobe");
    a_reserved_zero: assert property (reg_rvalid |-> reg_rdata[31:16] == 16'h0 && reg_rdata[14:5] == 10'h0)
        else $error("reserved bits read nonzero");
    a_idle_rdata: assert property (!reg_rvalid |-> reg_rdata == 32'h0)
        else $error("read data not zero when idle");
    a_unmapped_zero: assert property (reg_rd && reg_addr > `PMD_ADDR_OSC |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_mult_taken: assert property (mw && mok |=> pll_multiply_ratio == $past(wcode))
        else $error("valid multiplier code not taken");
    a_mult_kept: assert property (mw && !mok |=> $stable(pll_multiply_ratio))
        else $error("reserved multiplier code taken");
    a_mult_quiet: assert property (!mw |=> $stable(pll_multiply_ratio))
        else $error("multiplier changed without write");
    a_mode_set: assert property (cw && reg_wdata[0] |=> pll_mode_select)
        else $error("mode bit not set");
    a_mode_clear: assert property (cw && !reg_wdata[0] |=> !pll_mode_select)
        else $error("mode bit not cleared");
endmodule : pmd_clock_gen_chk
bind pmd_clock_gen pmd_clock_gen_chk pmd_clock_gen_chk_i (.clock, .rst_b, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .pll_multiply_ratio, .pll_mode_select);

/* File: pmd_clock_gen_tb_top.sv */
// Self-checking bench for the clock multiplier and divider block
`timescale 1ns/1ps
`include "pmd_defs.svh"
module pmd_clock_gen_tb_top;
    import pmd_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic osc_clock_in = 1'b0;
    logic pll_output_clock = 1'b0;
    logic memif_ext_clock_in = 1'b0;
    logic memif_clock_source_sel = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic pll_ref_clock;
    pmd_ratio_t pll_multiply_ratio;
    logic pll_mode_select;
    logic core_system_clock;
    logic periph_bus_clock;
    logic memif_system_clock;
    logic osc_clock_output;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int cnt [5];
    pmd_clock_gen pmd_clock_gen_i (.clock, .rst_b, .osc_clock_in, .pll_output_clock, .memif_ext_clock_in,
        .memif_clock_source_sel, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .pll_ref_clock, .pll_multiply_ratio, .pll_mode_select, .core_system_clock, .periph_bus_clock,
        .memif_system_clock, .osc_clock_output);
    always #12.5 clock = ~clock;
    // ----
    // Shared tasks
    // ----
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        n_fail += (got !== exp);
        if (got !== exp) $display("ERROR %s expected %h seen %h", what, exp, got);
    endtask : chk
    task automatic near(input string what, input int exp, input int got);
        comparisons++;
        n_fail += (got > exp + 1 || got < exp - 1);
        if (got > exp + 1 || got < exp - 1) $display("ERROR %s expected %0d seen %0d", what, exp, got);
    endtask : near
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, reg_rvalid});
        chk($sformatf("rdata %h", a), exp, reg_rdata);
    endtask : rd
    // Counts rising edges of each clock output; pins toggle every 4 cycles so the synchronisers keep up
    task automatic measure(input logic [2:0] run);
        logic [4:0] last;
        logic [4:0] now;
        cnt = '{default: 0};
        last = {pll_ref_clock, core_system_clock, periph_bus_clock, memif_system_clock, osc_clock_output};
        for (int i = 0; i < 512; i++)
        begin
            @(negedge clock);
            now = {pll_ref_clock, core_system_clock, periph_bus_clock, memif_system_clock, osc_clock_output};
            for (int k = 0; k < 5; k++) cnt[k] += (now[k] && !last[k]);
            last = now;
            osc_clock_in = osc_clock_in ^ (run[0] && i % 4 == 0);
            pll_output_clock = pll_output_clock ^ (run[1] && i % 4 == 0);
            memif_ext_clock_in = memif_ext_clock_in ^ (run[2] && i % 4 == 0);
        end
        // An unknown output would count as no edges, so a quiet clock must also be a known one
        chk("clock outputs known", 32'h0, {31'h0, $isunknown(now)});
    endtask : measure
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        rd(`PMD_ADDR_MULT, 32'h4);
        rd(`PMD_ADDR_DIV0, 32'h8000);
        rd(`PMD_ADDR_DIV1, 32'h8000);
        rd(`PMD_ADDR_DIV2, 32'h8001);
        rd(`PMD_ADDR_DIV3, 32'h8001);
        rd(`PMD_ADDR_OSC, 32'h8007);
        rd(`PMD_ADDR_CSR, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_fields();
        wr(`PMD_ADDR_DIV3, 32'hffffffff);
        rd(`PMD_ADDR_DIV3, 32'h801f);
        wr(`PMD_ADDR_DIV3, 32'h00000002);
        rd(`PMD_ADDR_DIV3, 32'h2);
        wr(`PMD_ADDR_MULT, 32'hffffffe5);
        rd(`PMD_ADDR_MULT, 32'h5);
        wr(`PMD_ADDR_MULT, 32'h3);
        wr(`PMD_ADDR_MULT, 32'h1a);
        rd(`PMD_ADDR_MULT, 32'h5);
        wr(`PMD_ADDR_MULT, 32'h19);
        chk("multiply", 32'h19, {27'h0, pll_multiply_ratio});
        wr(32'h01b7c128, 32'hffffffff);
        rd(32'h01b7c128, 32'h0);
        rd(32'h01b7c104, 32'h0);
        $display("t_fields done");
    endtask : t_fields
    task automatic t_osc_path();
        wr(`PMD_ADDR_OSC, 32'h8003);
        measure(3'b001);
        near("ref", 64, cnt[4]);
        near("core", 64, cnt[3]);
        near("periph", 32, cnt[2]);
        near("memif off", 0, cnt[1]);
        near("osc", 16, cnt[0]);
        $display("t_osc_path done");
    endtask : t_osc_path
    task automatic t_pll_path();
        wr(`PMD_ADDR_CSR, 32'h1);
        chk("mode", 32'h1, {31'h0, pll_mode_select});
        wr(`PMD_ADDR_DIV2, 32'h8003);
        wr(`PMD_ADDR_DIV1, 32'h8001);
        wr(`PMD_ADDR_DIV3, 32'h8002);
        measure(3'b010);
        near("core pll", 32, cnt[3]);
        near("periph pll", 16, cnt[2]);
        near("memif div", 21, cnt[1]);
        near("osc no pll", 0, cnt[0]);
        memif_clock_source_sel = 1'b1;
        wr(`PMD_ADDR_OSC, 32'hffff7fe0);
        rd(`PMD_ADDR_OSC, 32'h0);
        measure(3'b111);
        near("memif pin", 64, cnt[1]);
        near("osc off", 0, cnt[0]);
        wr(`PMD_ADDR_CSR, 32'hfffffffe);
        chk("mode off", 32'h0, {31'h0, pll_mode_select});
        rd(`PMD_ADDR_CSR, 32'h0);
        $display("t_pll_path done");
    endtask : t_pll_path
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (5) @(negedge clock);
        rst_b = 1'b1;
        t_reset();
        t_fields();
        t_osc_path();
        t_pll_path();
        rst_b = 1'b0;
        @(negedge clock);
        rst_b = 1'b1;
        t_reset();
        report_and_stop();
    end
endmodule : pmd_clock_gen_tb_top
